// ==== pll_consts.vh ====
`ifndef PLL_CONSTS_VH
`define PLL_CONSTS_VH
`define PLL_ADDR_W 10
`define PLL_STATUS_ADDR 10'h01F
`define PLL_STATUS_RST 8'h00
`define PLL_BIT_LOCK 0
`define PLL_BIT_PRI_THR 1
`define PLL_BIT_SEC_THR 2
`define PLL_BIT_VCO_THR 3
`define PLL_BIT_SEC_SEL 4
`define PLL_BIT_HOLD 5
`define PLL_BIT_CAL_DONE 6
`define PLL_NUM_STAT 7
`endif

// ==== pll_sync2.v ====
`timescale 1ns/10ps
module pll_sync2 (
  // clock and reset
  input wire clk_i,
  input wire nrst_i,
  // level in and out
  input wire [6:0] d_i,
  output wire [6:0] q_o
);
  reg [6:0] meta_r;
  reg [6:0] sync_r;
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      meta_r <= 7'h00;
      sync_r <= 7'h00;
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end
  assign q_o = sync_r;
endmodule // pll_sync2

// ==== pll_status_readback.v ====
// Notes on behaviour
// - Bit 5 reads 1 only while the device is actually in holdover, not merely when holdover is enabled.
// - Bit 4 reads 1 when the secondary reference feeds the PLL and 0 for primary or differential reference.
// - Bit 3 reads 1 when the VCO frequency is above the monitor threshold, else 0.
// - Bit 2 reads 1 when the secondary reference frequency exceeds the threshold chosen by 0x01A bit 6.
// - Bit 1 reads 1 when the primary reference frequency exceeds the threshold chosen by 0x01A bit 6.
// - Bit 0 shows the digital lock detector, 1 while locked.
// - The status register at pll_status_readback is read only and writes change none of its indications.
// - Bit 6 reads 1 once VCO calibration has finished and 0 before.
`timescale 1ns/10ps
`include "pll_consts.vh"
module pll_status_readback (
  // clock and reset
  input wire clk_i,
  input wire nrst_i,
  // register access
  input wire [`PLL_ADDR_W-1:0] addr_i,
  input wire rd_i,
  input wire wr_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  output wire hit_o,
  // monitor levels
  input wire holdover_active_i,
  input wire secondary_reference_input_sel_i,
  input wire vco_above_thr_i,
  input wire secondary_reference_input_above_thr_i,
  input wire primary_reference_input_above_thr_i,
  input wire lock_detect_i,
  input wire vco_cal_done_i
);
  localparam [7:0] STATUS_RST = `PLL_STATUS_RST;

  // monitor levels before and after the synchroniser
  wire [`PLL_NUM_STAT-1:0] raw_w;
  wire [`PLL_NUM_STAT-1:0] sync_w;
  // one flop per indication, fed only by the synchroniser
  reg lock_r;
  reg lock_nxt;
  reg pri_thr_r;
  reg pri_thr_nxt;
  reg sec_thr_r;
  reg sec_thr_nxt;
  reg vco_thr_r;
  reg vco_thr_nxt;
  reg sec_sel_r;
  reg sec_sel_nxt;
  reg hold_r;
  reg hold_nxt;
  reg cal_done_r;
  reg cal_done_nxt;
  // register image and read path
  wire [7:0] status_w;
  wire status_hit_w;
  wire [2:0] access_w;
  reg [7:0] rdata_nxt;

  function is_status;
    input [`PLL_ADDR_W-1:0] a;
    begin
      is_status = (a == `PLL_STATUS_ADDR);
    end
  endfunction

  // bit 7 has nothing behind it and reads zero
  function [7:0] pack_status;
    input cal_done;
    input hold;
    input sec_sel;
    input vco_thr;
    input sec_thr;
    input pri_thr;
    input lock;
    begin
      pack_status = 8'h00;
      pack_status[`PLL_BIT_CAL_DONE] = cal_done;
      pack_status[`PLL_BIT_HOLD] = hold;
      pack_status[`PLL_BIT_SEC_SEL] = sec_sel;
      pack_status[`PLL_BIT_VCO_THR] = vco_thr;
      pack_status[`PLL_BIT_SEC_THR] = sec_thr;
      pack_status[`PLL_BIT_PRI_THR] = pri_thr;
      pack_status[`PLL_BIT_LOCK] = lock;
    end
  endfunction

  assign raw_w[`PLL_BIT_LOCK] = lock_detect_i;
  assign raw_w[`PLL_BIT_PRI_THR] = primary_reference_input_above_thr_i;
  assign raw_w[`PLL_BIT_SEC_THR] = secondary_reference_input_above_thr_i;
  assign raw_w[`PLL_BIT_VCO_THR] = vco_above_thr_i;
  assign raw_w[`PLL_BIT_SEC_SEL] = secondary_reference_input_sel_i;
  assign raw_w[`PLL_BIT_HOLD] = holdover_active_i;
  assign raw_w[`PLL_BIT_CAL_DONE] = vco_cal_done_i;

  pll_sync2 u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .d_i(raw_w),
    .q_o(sync_w)
  );

  // indications follow the monitors only; no access path reaches them
  always @* begin
    lock_nxt = sync_w[`PLL_BIT_LOCK];
    pri_thr_nxt = sync_w[`PLL_BIT_PRI_THR];
    sec_thr_nxt = sync_w[`PLL_BIT_SEC_THR];
    vco_thr_nxt = sync_w[`PLL_BIT_VCO_THR];
    sec_sel_nxt = sync_w[`PLL_BIT_SEC_SEL];
    hold_nxt = sync_w[`PLL_BIT_HOLD];
    cal_done_nxt = sync_w[`PLL_BIT_CAL_DONE];
  end

  // sampled every cycle regardless of access
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      lock_r <= STATUS_RST[`PLL_BIT_LOCK];
    end else begin
      lock_r <= lock_nxt;
    end
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      pri_thr_r <= STATUS_RST[`PLL_BIT_PRI_THR];
    end else begin
      pri_thr_r <= pri_thr_nxt;
    end
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      sec_thr_r <= STATUS_RST[`PLL_BIT_SEC_THR];
    end else begin
      sec_thr_r <= sec_thr_nxt;
    end
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      vco_thr_r <= STATUS_RST[`PLL_BIT_VCO_THR];
    end else begin
      vco_thr_r <= vco_thr_nxt;
    end
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      sec_sel_r <= STATUS_RST[`PLL_BIT_SEC_SEL];
    end else begin
      sec_sel_r <= sec_sel_nxt;
    end
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      hold_r <= STATUS_RST[`PLL_BIT_HOLD];
    end else begin
      hold_r <= hold_nxt;
    end
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      cal_done_r <= STATUS_RST[`PLL_BIT_CAL_DONE];
    end else begin
      cal_done_r <= cal_done_nxt;
    end
  end

  assign status_w = pack_status(
    cal_done_r,
    hold_r,
    sec_sel_r,
    vco_thr_r,
    sec_thr_r,
    pri_thr_r,
    lock_r
  );

  assign status_hit_w = is_status(addr_i);
  assign hit_o = status_hit_w;
  assign access_w = {rd_i, wr_i, status_hit_w};

  // read data held between reads; writes never load anything
  always @* begin
    rdata_nxt = rdata_o;
    case (access_w)
      3'h0: begin
        rdata_nxt = rdata_o;
      end
      3'h1: begin
        rdata_nxt = rdata_o;
      end
      3'h2: begin
        rdata_nxt = rdata_o;
      end
      3'h3: begin
        rdata_nxt = rdata_o;
      end
      3'h4: begin
        rdata_nxt = 8'h00;
      end
      3'h5: begin
        rdata_nxt = status_w;
      end
      3'h6: begin
        rdata_nxt = 8'h00;
      end
      3'h7: begin
        rdata_nxt = status_w;
      end
      default: begin
        rdata_nxt = rdata_o;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rdata_nxt;
    end
  end
endmodule // pll_status_readback

// ==== pll_sr_sva.sv ====
`timescale 1ns/10ps
module pll_sr_sva (
  // clock and reset
  input wire clk_i,
  input wire nrst_i,
  // register access
  input wire [9:0] addr_i,
  input wire rd_i,
  input wire wr_i,
  input wire hit_o,
  input wire [7:0] rdata_o,
  // monitor levels
  input wire holdover_active_i,
  input wire secondary_reference_input_sel_i,
  input wire vco_above_thr_i,
  input wire secondary_reference_input_above_thr_i,
  input wire primary_reference_input_above_thr_i,
  input wire lock_detect_i,
  input wire vco_cal_done_i
);
  wire [6:0] m = {vco_cal_done_i, holdover_active_i, secondary_reference_input_sel_i, vco_above_thr_i,
    secondary_reference_input_above_thr_i, primary_reference_input_above_thr_i, lock_detect_i};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // read of the status address
  sequence rd_s;
    rd_i && hit_o;
  endsequence
  // synchroniser and field flops out of reset along the whole path
  sequence awake_s;
    $past(nrst_i, 1) && $past(nrst_i, 2) && $past(nrst_i, 3);
  endsequence
  // read data is the level sampled three edges before the read
  property p_bit(b);
    rd_s ##0 awake_s |=> rdata_o[b] == $past(m[b], 4);
  endproperty
  a_lock_bit: assert property (p_bit(0)) else $error("lock bit differs from monitor");
  a_pri_thr: assert property (p_bit(1)) else $error("primary threshold bit differs");
  a_sec_thr: assert property (p_bit(2)) else $error("secondary threshold bit differs");
  a_vco_thr: assert property (p_bit(3)) else $error("vco threshold bit differs");
  a_sec_sel: assert property (p_bit(4)) else $error("reference select bit differs");
  a_hold_bit: assert property (p_bit(5)) else $error("holdover bit differs");
  a_cal_done: assert property (p_bit(6)) else $error("calibration bit differs");
  a_wr_ignored: assert property (wr_i && !rd_i |=> $stable(rdata_o)) else $error("write moved read data");
  a_rd_held: assert property (!rd_i |=> $stable(rdata_o)) else $error("read data moved without read");
  a_hit_decode: assert property (hit_o == (addr_i == 10'h01F)) else $error("hit decode wrong");
  a_unmap_zero: assert property (rd_i && !hit_o |=> rdata_o == 8'h00) else $error("unmapped read not zero");
endmodule // pll_sr_sva

// ==== pll_status_readback_tb.sv ====
`timescale 1ns/10ps
module pll_status_readback_tb;
  // address, monitor levels, expected read data, expected hit
  typedef struct packed {
    logic [9:0] a;
    logic [6:0] m;
    logic [7:0] e;
    logic h;
  } pll_row_t;
  logic clk_i = 1'h0;
  logic nrst_i = 1'h0;
  logic rd_i = 1'h0;
  logic wr_i = 1'h0;
  logic hit_o;
  logic [9:0] addr_i = 10'h01F;
  logic [7:0] wdata_i = 8'hFF;
  logic [7:0] rdata_o;
  logic [6:0] m = 7'h00;
  pll_row_t rows [6] = '{
    {10'h01F, 7'h7F, 8'h7F, 1'h1},
    {10'h01F, 7'h00, 8'h00, 1'h1},
    {10'h01F, 7'h55, 8'h55, 1'h1},
    {10'h01F, 7'h2A, 8'h2A, 1'h1},
    {10'h01E, 7'h7F, 8'h00, 1'h0},
    {10'h01F, 7'h01, 8'h01, 1'h1}
  };
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  pll_status_readback dut (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .addr_i(addr_i),
    .rd_i(rd_i),
    .wr_i(wr_i),
    .wdata_i(wdata_i),
    .rdata_o(rdata_o),
    .hit_o(hit_o),
    .holdover_active_i(m[5]),
    .secondary_reference_input_sel_i(m[4]),
    .vco_above_thr_i(m[3]),
    .secondary_reference_input_above_thr_i(m[2]),
    .primary_reference_input_above_thr_i(m[1]),
    .lock_detect_i(m[0]),
    .vco_cal_done_i(m[6])
  );
  initial begin
    forever begin
      #5 clk_i = ~clk_i;
    end
  end
  // scripted run is under a hundred cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 500) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic rd(input logic [9:0] a);
    @(negedge clk_i);
    addr_i = a;
    rd_i = 1'h1;
    @(negedge clk_i);
    rd_i = 1'h0;
  endtask
  task automatic chk(input logic [7:0] e);
    n_checks++;
    if (rdata_o !== e) begin
      error_cnt++;
      $display("[ERR] rdata_o exp %h got %h", e, rdata_o);
    end
  endtask
  task automatic chk_hit(input logic e);
    n_checks++;
    if (hit_o !== e) begin
      error_cnt++;
      $display("[ERR] hit_o exp %h got %h", e, hit_o);
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk_i);
    nrst_i = 1'h1;
    // write strobe held while the levels settle
    foreach (rows[i]) begin
      m = rows[i].m;
      addr_i = rows[i].a;
      wr_i = 1'h1;
      repeat (6) @(negedge clk_i);
      wr_i = 1'h0;
      rd(rows[i].a);
      chk(rows[i].e);
      chk_hit(rows[i].h);
    end
    rd(10'h01F);
    chk(8'h01);
    // levels move, read data holds until the next read
    m = 7'h7F;
    repeat (6) @(negedge clk_i);
    chk(8'h01);
    // write in the same cycle as the read
    wr_i = 1'h1;
    wdata_i = 8'h00;
    rd(10'h01F);
    chk(8'h7F);
    wr_i = 1'h0;
    nrst_i = 1'h0;
    repeat (3) @(negedge clk_i);
    chk(8'h00);
    // first read after release sees the flushed synchroniser
    nrst_i = 1'h1;
    rd(10'h01F);
    chk(8'h00);
    rd(10'h01F);
    chk(8'h7F);
    final_report();
  end
endmodule // pll_status_readback_tb
bind pll_status_readback pll_sr_sva chk_u (
  .clk_i(clk_i),
  .nrst_i(nrst_i),
  .addr_i(addr_i),
  .rd_i(rd_i),
  .wr_i(wr_i),
  .hit_o(hit_o),
  .rdata_o(rdata_o),
  .holdover_active_i(holdover_active_i),
  .secondary_reference_input_sel_i(secondary_reference_input_sel_i),
  .vco_above_thr_i(vco_above_thr_i),
  .secondary_reference_input_above_thr_i(secondary_reference_input_above_thr_i),
  .primary_reference_input_above_thr_i(primary_reference_input_above_thr_i),
  .lock_detect_i(lock_detect_i),
  .vco_cal_done_i(vco_cal_done_i)
);
